//--- ptt_defs.svh
// constants for the periodic tick timebase: register layout and tap positions
`ifndef PTT_DEFS_SVH
`define PTT_DEFS_SVH

`define PTT_ADDR_W 4
`define PTT_DATA_W 8
`define PTT_DIV_W 15
`define PTT_RATE_W 3

// register offsets
`define PTT_OFS_CONTROL 4'h0
`define PTT_OFS_IRQ_STATUS 4'h1
`define PTT_OFS_IRQ_MASK 4'h2

// tick_control bit positions
`define PTT_BIT_FLAG 7
`define PTT_BIT_RATE_HI 6
`define PTT_BIT_RATE_LO 4
`define PTT_BIT_ACK 3
`define PTT_BIT_IRQ_EN 2
`define PTT_BIT_ON 1

// irq status / mask bit positions
`define PTT_EVT_TICK 0
`define PTT_EVT_OVERRUN 1
`define PTT_EVT_W 2

// reset values
`define PTT_RST_RATE 3'h0
`define PTT_RST_EVT 2'h0

// divider bit index whose rising edge marks each tap (tap = 2^(idx+1))
`define PTT_TAP_32768 4'hE
`define PTT_TAP_8192 4'hC
`define PTT_TAP_2048 4'hA
`define PTT_TAP_128 4'h6
`define PTT_TAP_64 4'h5
`define PTT_TAP_32 4'h4
`define PTT_TAP_16 4'h3

`endif

//--- ptt_pkg.sv
// types shared by the periodic tick timebase files
package ptt_pkg;
  typedef enum logic [2:0] {
    PTT_RATE_32768,
    PTT_RATE_8192,
    PTT_RATE_2048,
    PTT_RATE_128,
    PTT_RATE_64,
    PTT_RATE_32,
    PTT_RATE_16,
    PTT_RATE_1
  } ptt_rate_t;

  typedef enum logic [1:0] {
    PTT_MODE_RUN,
    PTT_MODE_WAIT,
    PTT_MODE_STOP
  } ptt_mode_t;
endpackage

//--- ptt_clk_select.sv
// tick source clock selection and stop-mode gating, registered as a level
`timescale 1ns/1ns
`include "ptt_defs.svh"
module ptt_clk_select
  import ptt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic external_clock,
  input wire logic internal_clock,
  input wire logic external_clock_on,
  input wire logic osc_keep_in_stop,
  input wire ptt_mode_t power_mode,
  output logic tick_source_clock
);
  typedef struct packed {
    logic tick;
  } ptt_cs_state_t;

  ptt_cs_state_t st;
  ptt_cs_state_t next_st;

  always_comb begin
    next_st = st;
    // external clock wins whenever enabled, even if bus runs internal
    next_st.tick = external_clock_on ? external_clock : internal_clock;
    // clock generator halts in stop unless kept running
    if (power_mode == PTT_MODE_STOP && !osc_keep_in_stop) begin
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_source_clock = st.tick;
endmodule

//--- ptt_divider.sv
// 15-stage divider chain with selectable rollover tap
`timescale 1ns/1ns
`include "ptt_defs.svh"
module ptt_divider
  import ptt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic timebase_on,
  input wire logic tick_en,
  input wire ptt_rate_t rate_select,
  output logic rollover
);
  typedef struct packed {
    logic [`PTT_DIV_W-1:0] count;
  } ptt_div_state_t;

  ptt_div_state_t st;
  ptt_div_state_t next_st;
  logic [3:0] tap_idx;
  logic [`PTT_DIV_W-1:0] inc;

  always_comb begin
    case (rate_select)
      PTT_RATE_32768: tap_idx = `PTT_TAP_32768;
      PTT_RATE_8192: tap_idx = `PTT_TAP_8192;
      PTT_RATE_2048: tap_idx = `PTT_TAP_2048;
      PTT_RATE_128: tap_idx = `PTT_TAP_128;
      PTT_RATE_64: tap_idx = `PTT_TAP_64;
      PTT_RATE_32: tap_idx = `PTT_TAP_32;
      PTT_RATE_16: tap_idx = `PTT_TAP_16;
      default: tap_idx = 4'h0;
    endcase
  end

  always_comb begin
    next_st = st;
    inc = st.count + 15'h0001;
    rollover = 1'b0;
    if (!timebase_on) begin
      next_st.count = '0;
    end else if (tick_en) begin
      next_st.count = inc;
      // rate 1 fires every source tick; others on tap bit rising
      if (rate_select == PTT_RATE_1) begin
        rollover = 1'b1;
      end else begin
        // tap bit low->high: first at half the tap count from zero, then every full tap
        rollover = !st.count[tap_idx] && inc[tap_idx];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

//--- ptt_timebase.sv
// periodic tick timebase: control register, sticky tick flag, interrupt logic
`timescale 1ns/1ns
`include "ptt_defs.svh"
module ptt_timebase
  import ptt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [`PTT_ADDR_W-1:0] reg_addr,
  input wire logic [`PTT_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`PTT_DATA_W-1:0] reg_rdata,
  input wire logic external_clock,
  input wire logic internal_clock,
  input wire logic external_clock_on,
  input wire logic osc_keep_in_stop,
  input wire ptt_mode_t power_mode,
  output logic tick_irq,
  output logic wake_request,
  output logic irq
);
  typedef struct packed {
    logic tick_flag;
    ptt_rate_t rate_select;
    logic tick_irq_enable;
    logic timebase_on;
    logic [`PTT_EVT_W-1:0] irq_status;
    logic [`PTT_EVT_W-1:0] irq_mask;
    logic [`PTT_DATA_W-1:0] rdata;
    logic src_prev;
  } ptt_state_t;

  ptt_state_t st;
  ptt_state_t next_st;
  logic tick_source_clock;
  logic tick_en;
  logic rollover;
  logic cpu_ok;
  logic wr;
  logic rd;
  logic [`PTT_EVT_W-1:0] evt;
  logic [`PTT_DATA_W-1:0] ctrl_view;

  ptt_clk_select u_clk_select (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .external_clock(external_clock),
    .internal_clock(internal_clock),
    .external_clock_on(external_clock_on),
    .osc_keep_in_stop(osc_keep_in_stop),
    .power_mode(power_mode),
    .tick_source_clock(tick_source_clock)
  );

  ptt_divider u_divider (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .timebase_on(st.timebase_on),
    .tick_en(tick_en),
    .rate_select(st.rate_select),
    .rollover(rollover)
  );

  // rising edge of the registered source gives one enable pulse per source period
  assign tick_en = tick_source_clock && !st.src_prev;
  // bus is cut off in wait and stop; the divider keeps running in wait
  assign cpu_ok = (power_mode == PTT_MODE_RUN);
  assign wr = reg_write && cpu_ok;
  assign rd = reg_read && cpu_ok;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[`PTT_BIT_FLAG] = st.tick_flag;
    ctrl_view[`PTT_BIT_RATE_HI:`PTT_BIT_RATE_LO] = st.rate_select;
    ctrl_view[`PTT_BIT_ACK] = 1'b0;
    ctrl_view[`PTT_BIT_IRQ_EN] = st.tick_irq_enable;
    ctrl_view[`PTT_BIT_ON] = st.timebase_on;
  end

  always_comb begin
    next_st = st;
    next_st.src_prev = tick_source_clock;
    evt = '0;
    evt[`PTT_EVT_TICK] = rollover;
    // a rollover while the flag still stands means a lost tick
    evt[`PTT_EVT_OVERRUN] = rollover && st.tick_flag;

    if (wr && reg_addr == `PTT_OFS_CONTROL) begin
      // flag bit itself ignores writes
      next_st.rate_select = ptt_rate_t'(reg_wdata[`PTT_BIT_RATE_HI:`PTT_BIT_RATE_LO]);
      next_st.tick_irq_enable = reg_wdata[`PTT_BIT_IRQ_EN];
      next_st.timebase_on = reg_wdata[`PTT_BIT_ON];
      if (reg_wdata[`PTT_BIT_ACK]) begin
        next_st.tick_flag = 1'b0;
      end
    end
    // set wins over a same-cycle acknowledge
    if (rollover) begin
      next_st.tick_flag = 1'b1;
    end

    if (wr && reg_addr == `PTT_OFS_IRQ_MASK) begin
      next_st.irq_mask = reg_wdata[`PTT_EVT_W-1:0];
    end
    if (wr && reg_addr == `PTT_OFS_IRQ_STATUS) begin
      next_st.irq_status = st.irq_status & ~reg_wdata[`PTT_EVT_W-1:0];
    end
    next_st.irq_status = next_st.irq_status | evt;

    next_st.rdata = '0;
    if (rd) begin
      case (reg_addr)
        `PTT_OFS_CONTROL: next_st.rdata = ctrl_view;
        `PTT_OFS_IRQ_STATUS: next_st.rdata[`PTT_EVT_W-1:0] = st.irq_status;
        `PTT_OFS_IRQ_MASK: next_st.rdata[`PTT_EVT_W-1:0] = st.irq_mask;
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st.tick_flag <= 1'b0;
      st.rate_select <= ptt_rate_t'(`PTT_RST_RATE);
      st.tick_irq_enable <= 1'b0;
      st.timebase_on <= 1'b0;
      st.irq_status <= `PTT_RST_EVT;
      st.irq_mask <= `PTT_RST_EVT;
      st.rdata <= '0;
      st.src_prev <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign tick_irq = st.tick_flag && st.tick_irq_enable;
  // the request doubles as wake source; stop only sees it if the source runs
  assign wake_request = tick_irq;
  assign irq = |(st.irq_status & st.irq_mask);
endmodule

//--- ptt_timebase_props.sv
// concurrent checks on the tick timebase ports
`timescale 1ns/1ns
module ptt_timebase_props
  import ptt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire ptt_mode_t power_mode,
  input wire logic tick_irq,
  input wire logic wake_request,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic run;
  assign run = power_mode == PTT_MODE_RUN;
  sequence s_wr_ctl;
    reg_write && run && reg_addr == 4'h0;
  endsequence
  sequence s_rd_ctl;
    reg_read && run && reg_addr == 4'h0;
  endsequence
  chk_wake_follow: assert property (wake_request == tick_irq)
    else $error("wake differs");
  chk_rdata_quiet: assert property (
    (!reg_read || !run || reg_addr > 4'h2) |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_ack_zero: assert property (s_rd_ctl |=> !reg_rdata[3] && !reg_rdata[0])
    else $error("ack bit reads one");
  chk_ctl_back: assert property (
    s_wr_ctl ##1 s_rd_ctl |=> reg_rdata[6:1] == ($past(reg_wdata[6:1], 2) & 6'h3B))
    else $error("control readback");
  chk_flag_sticky: assert property (
    $fell(tick_irq) |-> $past(reg_write && run && reg_addr == 4'h0))
    else $error("flag dropped alone");
  chk_irq_hold: assert property (tick_irq && !reg_write |=> tick_irq)
    else $error("request dropped");
  chk_ien_off: assert property (s_wr_ctl ##0 !reg_wdata[2] |=> !tick_irq)
    else $error("request while disabled");
  chk_mask_off: assert property (
    reg_write && run && reg_addr == 4'h2 && reg_wdata[1:0] == 2'h0 |=> !irq)
    else $error("masked irq high");
endmodule
bind ptt_timebase ptt_timebase_props u_props(.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .power_mode, .tick_irq, .wake_request, .irq);

//--- ptt_clk_src.sv
// tick source model: internal and external oscillators as slow levels
`timescale 1ns/1ns
module ptt_clk_src (
  input wire logic sys_clk,
  output logic internal_clock,
  output logic external_clock
);
  logic [1:0] a;
  logic [1:0] b;
  initial begin
    a = 2'h0;
    b = 2'h0;
    internal_clock = 1'b0;
    external_clock = 1'b0;
  end
  // 4 and 6 cycle periods, slow enough that every edge is sampled
  always @(posedge sys_clk) begin
    a <= a + 2'h1;
    internal_clock <= a[1];
    b <= (b == 2'h2) ? 2'h0 : b + 2'h1;
    if (b == 2'h2)
      external_clock <= ~external_clock;
  end
endmodule

//--- tb_ptt_timebase.sv
// self-checking bench for the periodic tick timebase
`timescale 1ns/1ns
module tb_ptt_timebase
  import ptt_pkg::*;
;
  logic sys_clk, sys_rst, reg_write, reg_read, ext_on, keep;
  logic internal_clock, external_clock, tick_irq, wake_request, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  ptt_mode_t power_mode;
  int mismatches, n_checks;
  time t_prev, t_last;
  ptt_clk_src SRC(.sys_clk, .internal_clock, .external_clock);
  ptt_timebase DUT(.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .external_clock, .internal_clock, .external_clock_on(ext_on),
    .osc_keep_in_stop(keep), .power_mode, .tick_irq, .wake_request, .irq);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge tick_irq) begin
    t_prev = t_last;
    t_last = $time;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, 8'h00);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    #1 chk(reg_rdata, e);
  endtask
  task wait_irq(input int lim);
    #1;
    while (tick_irq !== 1'b1 && lim > 0) begin
      @(posedge sys_clk);
      #1;
      lim--;
    end
  endtask
  task reset_values;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h9, 8'h00);
  endtask
  task rate_codes;
    // ack written as one, must read back as zero
    for (int r = 0; r < 8; r++) begin
      bus(1'b1, 1'b0, 4'h0, {1'b0, 3'(r), 4'hC});
      rd(4'h0, {1'b0, 3'(r), 4'h4});
    end
    wr(4'h0, 8'h00);
  endtask
  task irq_flow;
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h62);
    repeat (200) @(posedge sys_clk);
    #1 chk({tick_irq, irq}, 2'b01);
    wr(4'h2, 8'h00);
    #1 chk(irq, 1'b0);
    rd(4'h1, 8'h03);
    rd(4'h0, 8'hE2);
    wr(4'h0, 8'h68);
    rd(4'h0, 8'h60);
    wr(4'h1, 8'h03);
    wr(4'h2, 8'h01);
    rd(4'h1, 8'h00);
    chk(irq, 1'b0);
  endtask
  task rate_run(input logic [2:0] r, input int n, input int p);
    wr(4'h0, {1'b0, r, 4'h0});
    wr(4'h0, {1'b0, r, 4'h6});
    wait_irq(n * p * 2 + 20);
    wr(4'h0, {1'b0, r, 4'hE});
    wait_irq(n * p + 20);
    chk(16'(t_last - t_prev), 16'(n * p * 10));
    wr(4'h0, {1'b0, r, 4'h8});
  endtask
  task low_power;
    wr(4'h0, 8'h66);
    @(posedge sys_clk) power_mode <= PTT_MODE_WAIT;
    rd(4'h0, 8'h00);
    wait_irq(300);
    chk(tick_irq, 1'b1);
    @(posedge sys_clk) power_mode <= PTT_MODE_RUN;
    wr(4'h0, 8'h6E);
    @(posedge sys_clk) power_mode <= PTT_MODE_STOP;
    repeat (300) @(posedge sys_clk);
    chk(wake_request, 1'b0);
    keep <= 1'b1;
    wait_irq(300);
    chk(wake_request, 1'b1);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    print_verdict;
  end
  initial begin
    {mismatches, n_checks, t_prev, t_last} = '0;
    {reg_write, reg_read, reg_addr, reg_wdata, ext_on, keep} = '0;
    power_mode = PTT_MODE_RUN;
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    reset_values;
    rate_codes;
    irq_flow;
    rate_run(3'h6, 16, 4);
    rate_run(3'h5, 32, 4);
    rate_run(3'h4, 64, 4);
    rate_run(3'h3, 128, 4);
    ext_on <= 1'b1;
    rate_run(3'h7, 1, 6);
    ext_on <= 1'b0;
    low_power;
    print_verdict;
  end
endmodule
